// ---- core/ehci_status_pkg.sv ----
// Package: offsets, field positions, reset values and states of the status bank
package ehci_status_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  typedef logic [ADDR_W-1:0] addr_t;
  typedef logic [DATA_W-1:0] word_t;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam addr_t CMD_OFFSET    = 8'h20;
  localparam addr_t STATUS_OFFSET = 8'h24;
  localparam addr_t IRQ_EN_OFFSET = 8'h28;

  // ----------------------------------------------------------------
  // Command register fields
  // ----------------------------------------------------------------
  localparam int RUN_STOP_BIT    = 0;
  localparam int PERIODIC_EN_BIT = 4;
  localparam int ASYNC_EN_BIT    = 5;
  localparam int DOORBELL_BIT    = 6;

  // ----------------------------------------------------------------
  // Status and interrupt enable fields (same layout for events)
  // ----------------------------------------------------------------
  localparam int ASYNC_STAT_BIT    = 15;
  localparam int PERIODIC_STAT_BIT = 14;
  localparam int EMPTY_DETECT_BIT  = 13;
  localparam int HALTED_BIT        = 12;
  localparam int ASYNC_ADV_BIT     = 5;
  localparam int SYS_ERR_BIT       = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic  FLAG_RST   = 1'b0;
  localparam logic  HALTED_RST = 1'b1;
  localparam word_t IDLE_WORD  = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Halt tracking states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    RUN_ST      = 3'b001,
    STOPPING_ST = 3'b010,
    HALT_ST     = 3'b100
  } halt_state_e;

endpackage

// ---- core/sched_if.sv ----
// Interface: run control and schedule state between bank and tracker
`timescale 1ns/10ps
interface sched_if;
  logic run_stop;
  logic async_sched_enable;
  logic periodic_sched_enable;
  logic frame_tick;
  logic engine_idle;
  logic async_sched_status;
  logic periodic_sched_status;
  logic halted_flag;

  modport ctrl (
    output run_stop,
    output async_sched_enable,
    output periodic_sched_enable,
    output frame_tick,
    output engine_idle,
    input  async_sched_status,
    input  periodic_sched_status,
    input  halted_flag
  );

  modport trk (
    input  run_stop,
    input  async_sched_enable,
    input  periodic_sched_enable,
    input  frame_tick,
    input  engine_idle,
    output async_sched_status,
    output periodic_sched_status,
    output halted_flag
  );
endinterface

// ---- core/sched_tracker.sv ----
// Schedule state tracker: lagging schedule status and halt sequencing
`timescale 1ns/10ps
module sched_tracker (
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  sched_if.trk      sif
);
  import ehci_status_pkg::*;

  halt_state_e state_reg;
  halt_state_e state_next;
  logic        async_stat_reg;
  logic        async_stat_next;
  logic        periodic_stat_reg;
  logic        periodic_stat_next;
  wire  logic  in_halt;

  // ----------------------------------------------------------------
  // Halt sequencing
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      HALT_ST: begin
        if (sif.run_stop) begin
          state_next = RUN_ST;
        end
      end
      RUN_ST: begin
        if (!sif.run_stop) begin
          state_next = STOPPING_ST;
        end
      end
      STOPPING_ST: begin
        // Engine must drain its current transfer before halting
        if (sif.run_stop) begin
          state_next = RUN_ST;
        end else if (sif.engine_idle) begin
          state_next = HALT_ST;
        end
      end
    endcase
  end

  assign in_halt = (state_reg == HALT_ST);

  // Schedules change state at a frame boundary, hence the lag; a halt clears both on the next clock
  assign async_stat_next = sif.frame_tick ?
    (sif.async_sched_enable & ~in_halt) : async_stat_reg;
  assign periodic_stat_next = sif.frame_tick ?
    (sif.periodic_sched_enable & ~in_halt) : periodic_stat_reg;

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      state_reg         <= HALT_ST;
      async_stat_reg    <= FLAG_RST;
      periodic_stat_reg <= FLAG_RST;
    end else begin
      state_reg         <= state_next;
      async_stat_reg    <= async_stat_next & ~in_halt;
      periodic_stat_reg <= periodic_stat_next & ~in_halt;
    end
  end

  assign sif.async_sched_status    = async_stat_reg;
  assign sif.periodic_sched_status = periodic_stat_reg;
  assign sif.halted_flag           = in_halt & ~sif.run_stop;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);

  a_async_follows_enable: assert property (
    sif.frame_tick && !in_halt && state_next != HALT_ST
    |=> sif.async_sched_status == $past(sif.async_sched_enable))
    else $error("async status did not follow enable at frame");

  a_periodic_holds_between: assert property (
    !sif.frame_tick && !in_halt && state_next != HALT_ST
    |=> $stable(sif.periodic_sched_status))
    else $error("periodic status moved between frames");

  a_halt_after_drain: assert property (
    state_reg == STOPPING_ST && sif.engine_idle && !sif.run_stop
    |=> sif.halted_flag || sif.run_stop)
    else $error("halted not set after engine drained");
endmodule

// ---- core/ehci_status_flags_upper.sv ----
// Status bank: command, status and interrupt enable registers, bits 15 to 4 and command bit 0
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/10ps
module ehci_status_flags_upper (
  input  wire logic                   clk_in,
  input  wire logic                   rst_b_in,
  input  wire ehci_status_pkg::addr_t addr_in,
  input  wire ehci_status_pkg::word_t wdata_in,
  input  wire logic                   wr_in,
  input  wire logic                   rd_in,
  output ehci_status_pkg::word_t      rdata_out,
  input  wire logic                   async_advanced_in,
  input  wire logic                   async_empty_in,
  input  wire logic                   host_error_in,
  input  wire logic                   frame_tick_in,
  input  wire logic                   engine_idle_in,
  input  wire logic                   irq_threshold_in,
  output logic                        run_stop_out,
  output logic                        async_sched_enable_out,
  output logic                        periodic_sched_enable_out,
  output logic                        async_sched_status_out,
  output logic                        periodic_sched_status_out,
  output logic                        halted_flag_out,
  output logic                        irq_out
);
  import ehci_status_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic reg_hit(input addr_t a, input addr_t off);
    reg_hit = (a == off);
  endfunction

  // Hardware set wins over a same-cycle software clear
  function automatic logic flag_upd(input logic cur,
                                    input logic set,
                                    input logic clr);
    flag_upd = set | (cur & ~clr);
  endfunction

  // One flag at its field position; keeps words free of bare offsets
  function automatic word_t bit_at(input logic v, input int pos);
    bit_at = word_t'(v) << pos;
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic  run_stop_reg;
  logic  run_stop_next;
  logic  async_en_reg;
  logic  async_en_next;
  logic  periodic_en_reg;
  logic  periodic_en_next;
  logic  doorbell_reg;
  logic  doorbell_next;
  logic  async_adv_reg;
  logic  async_adv_next;
  logic  sys_err_reg;
  logic  sys_err_next;
  logic  empty_detect_reg;
  logic  adv_irq_en_reg;
  logic  adv_irq_en_next;
  logic  err_irq_en_reg;
  logic  err_irq_en_next;
  logic  adv_irq_reg;
  logic  adv_irq_next;
  word_t rdata_reg;
  word_t rdata_next;

  wire logic  cmd_wr;
  wire logic  sts_wr;
  wire logic  irq_en_wr;
  wire logic  cmd_rd;
  wire logic  sts_rd;
  wire logic  irq_en_rd;
  wire logic  adv_set;
  wire logic  adv_clr;
  wire logic  err_clr;
  wire logic  ring;
  wire word_t cmd_word;
  wire word_t status_word;
  wire word_t irq_en_word;

  sched_if sif ();

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  assign cmd_wr    = wr_in & reg_hit(addr_in, CMD_OFFSET);
  assign sts_wr    = wr_in & reg_hit(addr_in, STATUS_OFFSET);
  assign irq_en_wr = wr_in & reg_hit(addr_in, IRQ_EN_OFFSET);
  assign cmd_rd    = rd_in & reg_hit(addr_in, CMD_OFFSET);
  assign sts_rd    = rd_in & reg_hit(addr_in, STATUS_OFFSET);
  assign irq_en_rd = rd_in & reg_hit(addr_in, IRQ_EN_OFFSET);

  // ----------------------------------------------------------------
  // Command register
  // ----------------------------------------------------------------
  // A bus fault overrides a run request written in the same cycle
  assign run_stop_next = host_error_in ? 1'b0 :
    (cmd_wr ? wdata_in[RUN_STOP_BIT] : run_stop_reg);
  assign async_en_next = cmd_wr ?
    wdata_in[ASYNC_EN_BIT] : async_en_reg;
  assign periodic_en_next = cmd_wr ?
    wdata_in[PERIODIC_EN_BIT] : periodic_en_reg;

  // Doorbell stays rung until the next schedule advance answers it
  assign ring          = cmd_wr & wdata_in[DOORBELL_BIT];
  assign adv_set       = doorbell_reg & async_advanced_in;
  assign doorbell_next = ring | (doorbell_reg & ~adv_set);

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      run_stop_reg    <= FLAG_RST;
      async_en_reg    <= FLAG_RST;
      periodic_en_reg <= FLAG_RST;
      doorbell_reg    <= FLAG_RST;
    end else begin
      run_stop_reg    <= run_stop_next;
      async_en_reg    <= async_en_next;
      periodic_en_reg <= periodic_en_next;
      doorbell_reg    <= doorbell_next;
    end
  end

  // ----------------------------------------------------------------
  // Status events
  // ----------------------------------------------------------------
  // Only event bits take write-one-clear; all else ignores writes
  assign adv_clr = sts_wr & wdata_in[ASYNC_ADV_BIT];
  assign err_clr = sts_wr & wdata_in[SYS_ERR_BIT];

  assign async_adv_next = flag_upd(async_adv_reg, adv_set, adv_clr);
  assign sys_err_next = flag_upd(sys_err_reg, host_error_in, err_clr);

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      async_adv_reg    <= FLAG_RST;
      sys_err_reg      <= FLAG_RST;
      empty_detect_reg <= FLAG_RST;
    end else begin
      async_adv_reg    <= async_adv_next;
      sys_err_reg      <= sys_err_next;
      empty_detect_reg <= async_empty_in;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt enable and output
  // ----------------------------------------------------------------
  assign adv_irq_en_next = irq_en_wr ?
    wdata_in[ASYNC_ADV_BIT] : adv_irq_en_reg;
  assign err_irq_en_next = irq_en_wr ?
    wdata_in[SYS_ERR_BIT] : err_irq_en_reg;

  // Advance interrupt waits for a threshold, then holds until cleared
  assign adv_irq_next = async_adv_next & adv_irq_en_next &
    (adv_irq_reg | irq_threshold_in);

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      adv_irq_en_reg <= FLAG_RST;
      err_irq_en_reg <= FLAG_RST;
      adv_irq_reg    <= FLAG_RST;
    end else begin
      adv_irq_en_reg <= adv_irq_en_next;
      err_irq_en_reg <= err_irq_en_next;
      adv_irq_reg    <= adv_irq_next;
    end
  end

  assign irq_out = adv_irq_reg | (sys_err_reg & err_irq_en_reg);

  // ----------------------------------------------------------------
  // Schedule tracker
  // ----------------------------------------------------------------
  assign sif.run_stop              = run_stop_reg;
  assign sif.async_sched_enable    = async_en_reg;
  assign sif.periodic_sched_enable = periodic_en_reg;
  assign sif.frame_tick            = frame_tick_in;
  assign sif.engine_idle           = engine_idle_in;

  sched_tracker u_tracker (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .sif      (sif.trk)
  );

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  assign cmd_word = bit_at(doorbell_reg, DOORBELL_BIT) |
                    bit_at(async_en_reg, ASYNC_EN_BIT) |
                    bit_at(periodic_en_reg, PERIODIC_EN_BIT) |
                    bit_at(run_stop_reg, RUN_STOP_BIT);

  // Reserved ranges always read as zero
  assign status_word =
    bit_at(sif.async_sched_status, ASYNC_STAT_BIT) |
    bit_at(sif.periodic_sched_status, PERIODIC_STAT_BIT) |
    bit_at(empty_detect_reg, EMPTY_DETECT_BIT) |
    bit_at(sif.halted_flag, HALTED_BIT) |
    bit_at(async_adv_reg, ASYNC_ADV_BIT) |
    bit_at(sys_err_reg, SYS_ERR_BIT);

  assign irq_en_word = bit_at(adv_irq_en_reg, ASYNC_ADV_BIT) |
                       bit_at(err_irq_en_reg, SYS_ERR_BIT);

  // Unmapped reads, and idle cycles, give zero
  assign rdata_next = cmd_rd    ? cmd_word    :
                      sts_rd    ? status_word :
                      irq_en_rd ? irq_en_word : IDLE_WORD;

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      rdata_reg <= IDLE_WORD;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rdata_out                 = rdata_reg;
  assign run_stop_out              = run_stop_reg;
  assign async_sched_enable_out    = async_en_reg;
  assign periodic_sched_enable_out = periodic_en_reg;
  assign async_sched_status_out    = sif.async_sched_status;
  assign periodic_sched_status_out = sif.periodic_sched_status;
  assign halted_flag_out           = sif.halted_flag;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);

  a_running_not_halted: assert property (
    run_stop_reg |-> !halted_flag_out)
    else $error("halted reads one while running");

  a_halt_reset_value: assert property (
    $rose(rst_b_in) && !run_stop_reg |-> halted_flag_out)
    else $error("halted not one after reset");

  a_error_sets_flag: assert property (
    host_error_in |=> sys_err_reg)
    else $error("system error flag not set");

  a_error_stops_run: assert property (
    host_error_in |=> !run_stop_out ##1 !run_stop_out || $past(cmd_wr))
    else $error("run/stop not cleared by system error");

  a_doorbell_sets_adv: assert property (
    doorbell_reg && async_advanced_in
    |=> async_adv_reg && (doorbell_reg == $past(ring)))
    else $error("advance flag not set on advance");

  a_adv_needs_doorbell: assert property (
    !async_adv_reg && !(doorbell_reg && async_advanced_in)
    |=> !async_adv_reg)
    else $error("advance flag set without doorbell");

  a_w1c_clears_err: assert property (
    err_clr && !host_error_in |=> !sys_err_reg)
    else $error("system error flag not cleared by write");

  a_w0_keeps_adv: assert property (
    sts_wr && !wdata_in[ASYNC_ADV_BIT] && async_adv_reg
    |=> async_adv_reg)
    else $error("advance flag lost on zero write");

  a_empty_read_only: assert property (
    1'b1 |=> empty_detect_reg == $past(async_empty_in))
    else $error("empty detect not tracking engine");

  a_err_irq_level: assert property (
    sys_err_reg && err_irq_en_reg |-> irq_out)
    else $error("enabled system error gives no interrupt");

  a_adv_irq_thresh: assert property (
    irq_threshold_in && async_adv_reg && adv_irq_en_reg &&
    !adv_clr && !irq_en_wr |=> irq_out)
    else $error("advance interrupt missing at threshold");

  a_adv_irq_waits: assert property (
    !adv_irq_reg && !irq_threshold_in && !(sys_err_reg && err_irq_en_reg)
    |=> !adv_irq_reg)
    else $error("advance interrupt before threshold");

  a_status_read_data: assert property (
    sts_rd |=> rdata_out == $past(status_word) ##1
    (rdata_out == IDLE_WORD || $past(rd_in)))
    else $error("status read data wrong or held");

  a_adv_w1c_clears: assert property (
    adv_clr && !adv_set |=> !async_adv_reg)
    else $error("advance flag not cleared by write");

  a_w0_keeps_err: assert property (
    sts_wr && !wdata_in[SYS_ERR_BIT] && sys_err_reg |=> sys_err_reg)
    else $error("system error flag lost on zero write");

  a_err_needs_event: assert property (
    !sys_err_reg && !host_error_in |=> !sys_err_reg)
    else $error("system error flag set without fault");

  a_bell_holds: assert property (
    doorbell_reg && !async_advanced_in |=> doorbell_reg)
    else $error("doorbell dropped before an advance");

  a_adv_ack_drops_irq: assert property (
    adv_clr && !adv_set |=> !irq_out || (sys_err_reg && err_irq_en_reg))
    else $error("advance interrupt held after flag cleared");

  a_irq_has_source: assert property (
    irq_out |-> (async_adv_reg && adv_irq_en_reg) ||
    (sys_err_reg && err_irq_en_reg))
    else $error("interrupt without an enabled flag");

  a_halt_clears_status: assert property (
    halted_flag_out
    |=> !async_sched_status_out && !periodic_sched_status_out)
    else $error("schedule status left on while halted");

  a_enable_write_lands: assert property (
    cmd_wr |=> async_en_reg == $past(wdata_in[ASYNC_EN_BIT]))
    else $error("async enable write did not land");
endmodule

// ---- sim/testbench.sv ----
// Testbench: register bus, schedule status, halt and event flag scenarios
`timescale 1ns/10ps
`define CHK(nm, exp, got) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
      fail_count++; \
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); \
    end \
  end

module testbench;
  import ehci_status_pkg::*;

  logic       clk_in;
  logic       rst_b_in;
  addr_t      addr_in;
  word_t      wdata_in;
  logic       wr_in;
  logic       rd_in;
  word_t      rdata_out;
  logic [3:0] pls;
  logic       async_empty_in;
  logic       engine_idle_in;
  logic       run_stop_out;
  logic       async_en;
  logic       periodic_en;
  logic       async_stat;
  logic       periodic_stat;
  logic       halted_flag_out;
  logic       irq_out;
  int         fail_count;
  int         tests_run;
  word_t      d;

  ehci_status_flags_upper i_ehci_status_flags_upper (
    .clk_in                    (clk_in),
    .rst_b_in                  (rst_b_in),
    .addr_in                   (addr_in),
    .wdata_in                  (wdata_in),
    .wr_in                     (wr_in),
    .rd_in                     (rd_in),
    .rdata_out                 (rdata_out),
    .async_advanced_in         (pls[0]),
    .async_empty_in            (async_empty_in),
    .host_error_in             (pls[1]),
    .frame_tick_in             (pls[2]),
    .engine_idle_in            (engine_idle_in),
    .irq_threshold_in          (pls[3]),
    .run_stop_out              (run_stop_out),
    .async_sched_enable_out    (async_en),
    .periodic_sched_enable_out (periodic_en),
    .async_sched_status_out    (async_stat),
    .periodic_sched_status_out (periodic_stat),
    .halted_flag_out           (halted_flag_out),
    .irq_out                   (irq_out)
  );

  // ----------------------------------------------------------------
  // Clock and bus tasks
  // ----------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic wr(input addr_t a, input word_t v);
    @(posedge clk_in);
    addr_in  <= a;
    wdata_in <= v;
    wr_in    <= 1'b1;
    @(posedge clk_in);
    wr_in    <= 1'b0;
    #1;
  endtask

  // Data stand only in the cycle after the read edge
  task automatic rd(input addr_t a, output word_t v);
    @(posedge clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clk_in);
    rd_in   <= 1'b0;
    #1;
    v = rdata_out;
  endtask

  // 0 advance, 1 host error, 2 frame tick, 3 irq threshold
  task automatic pulse(input int k);
    @(posedge clk_in);
    pls <= 4'h1 << k;
    @(posedge clk_in);
    pls <= 4'h0;
    #1;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic s_reset;
    rd(STATUS_OFFSET, d);
    `CHK("status reset", 32'h0000_1000, d)
    `CHK("halted reset", 1'b1, halted_flag_out)
    rd(CMD_OFFSET, d);
    `CHK("cmd reset", 32'h0000_0000, d)
    rd(8'h2c, d);
    `CHK("unmapped read", 32'h0000_0000, d)
    rd(IRQ_EN_OFFSET, d);
    `CHK("irq en reset", 32'h0000_0000, d)
    `CHK("irq reset", 1'b0, irq_out)
  endtask

  task automatic s_run_lag;
    wr(CMD_OFFSET, 32'h0000_0031);
    `CHK("run", 1'b1, run_stop_out)
    `CHK("halted run", 1'b0, halted_flag_out)
    `CHK("async en", 1'b1, async_en)
    `CHK("periodic en", 1'b1, periodic_en)
    `CHK("async lag", 1'b0, async_stat)
    `CHK("periodic lag", 1'b0, periodic_stat)
    pulse(2);
    `CHK("async stat", 1'b1, async_stat)
    `CHK("periodic stat", 1'b1, periodic_stat)
    @(posedge clk_in);
    async_empty_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rd(STATUS_OFFSET, d);
    `CHK("status running", 32'h0000_e000, d)
    // Reserved bits go back as zero; state bits must ignore the write
    wr(STATUS_OFFSET, 32'h0000_f000);
    rd(STATUS_OFFSET, d);
    `CHK("state read only", 32'h0000_e000, d)
    wr(CMD_OFFSET, 32'h0000_0011);
    `CHK("async still on", 1'b1, async_stat)
    pulse(2);
    `CHK("async off", 1'b0, async_stat)
    `CHK("periodic on", 1'b1, periodic_stat)
  endtask

  task automatic s_doorbell;
    pulse(0);
    rd(STATUS_OFFSET, d);
    `CHK("no bell no flag", 1'b0, d[ASYNC_ADV_BIT])
    wr(IRQ_EN_OFFSET, 32'h0000_0020);
    rd(IRQ_EN_OFFSET, d);
    `CHK("irq enable word", 32'h0000_0020, d)
    wr(CMD_OFFSET, 32'h0000_0051);
    rd(CMD_OFFSET, d);
    `CHK("bell pending", 1'b1, d[DOORBELL_BIT])
    `CHK("cmd word", 32'h0000_0051, d)
    pulse(0);
    rd(STATUS_OFFSET, d);
    `CHK("advance flag", 1'b1, d[ASYNC_ADV_BIT])
    `CHK("irq waits", 1'b0, irq_out)
    rd(CMD_OFFSET, d);
    `CHK("bell answered", 32'h0000_0011, d)
    pulse(3);
    `CHK("irq at threshold", 1'b1, irq_out)
    wr(STATUS_OFFSET, 32'h0000_0000);
    `CHK("w0 keeps irq", 1'b1, irq_out)
    wr(STATUS_OFFSET, 32'h0000_0020);
    `CHK("irq acked", 1'b0, irq_out)
    rd(STATUS_OFFSET, d);
    `CHK("flag cleared", 1'b0, d[ASYNC_ADV_BIT])
  endtask

  task automatic s_error;
    int n;
    wr(IRQ_EN_OFFSET, 32'h0000_0010);
    pulse(1);
    `CHK("error stops", 1'b0, run_stop_out)
    `CHK("error irq", 1'b1, irq_out)
    `CHK("not yet halted", 1'b0, halted_flag_out)
    rd(STATUS_OFFSET, d);
    `CHK("error flag", 1'b1, d[SYS_ERR_BIT])
    @(posedge clk_in);
    engine_idle_in <= 1'b1;
    n = 0;
    while (halted_flag_out !== 1'b1 && n < 8) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    `CHK("halted after stop", 1'b1, halted_flag_out)
    pulse(2);
    `CHK("periodic stopped", 1'b0, periodic_stat)
    wr(IRQ_EN_OFFSET, 32'h0000_0000);
    `CHK("error masked", 1'b0, irq_out)
    wr(STATUS_OFFSET, 32'h0000_0010);
    rd(STATUS_OFFSET, d);
    `CHK("error cleared", 1'b0, d[SYS_ERR_BIT])
    `CHK("halted bit", 1'b1, d[HALTED_BIT])
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    fail_count     = 0;
    tests_run      = 0;
    rst_b_in       = 1'b0;
    addr_in        = '0;
    wdata_in       = '0;
    wr_in          = 1'b0;
    rd_in          = 1'b0;
    pls            = 4'h0;
    async_empty_in = 1'b0;
    engine_idle_in = 1'b0;
    repeat (2) @(posedge clk_in);
    rst_b_in <= 1'b1;
    s_reset();
    s_run_lag();
    s_doorbell();
    s_error();
    report_and_stop();
  end

  // Hang guard well beyond the longest scenario
  initial begin
    #100000;
    fail_count++;
    report_and_stop();
  end
endmodule
